// [rtl/rtu_consts.vh]
// constants for the rtu slave frame handler
`ifndef RTU_CONSTS_VH
`define RTU_CONSTS_VH

// ----------------------------------------------------------------
// command and exception codes
// ----------------------------------------------------------------
`define RTU_CMD_READ 8'h03
`define RTU_CMD_WRITE 8'h06
`define RTU_EXC_FLAG 8'h80
`define RTU_EXC_CMD 8'h01
`define RTU_EXC_ADDR 8'h02
`define RTU_EXC_VALUE 8'h03
`define RTU_EXC_FAIL 8'h04

// ----------------------------------------------------------------
// station addressing
// ----------------------------------------------------------------
`define RTU_BCAST 8'h00
`define RTU_ADDR_MAX 8'hf7

// ----------------------------------------------------------------
// frame layout and check
// ----------------------------------------------------------------
`define RTU_REQ_LEN 4'h8
`define RTU_REQ_OVER 4'h9
`define RTU_MAX_WORDS 12
`define RTU_CRC_INIT 16'hffff
`define RTU_CRC_POLY 16'ha001
`define RTU_EXC_LEN 5'h05
`define RTU_WR_LEN 5'h08
`define RTU_RD_OVH 5'h05

// ----------------------------------------------------------------
// group select ranges (high byte of the parameter address)
// ----------------------------------------------------------------
`define RTU_CFG_LO 8'ha0
`define RTU_CFG_HI 8'hbf
`define RTU_MON_LO 8'h70
`define RTU_MON_HI 8'h7f
`define RTU_RAM_LO 8'h40
`define RTU_RAM_HI 8'h5f
`define RTU_IDX_END 9'h100

// ----------------------------------------------------------------
// timing: 3.5 chars of 11 bits at 9600 baud, rounded up
// ----------------------------------------------------------------
`define RTU_GAP_TIME_US 4011
`define RTU_CLK_MHZ 125
`define RTU_GAP_CYCLES (`RTU_GAP_TIME_US * `RTU_CLK_MHZ)

// ----------------------------------------------------------------
// state codes
// ----------------------------------------------------------------
`define RTU_S_RX 4'h0
`define RTU_S_EXEC 4'h1
`define RTU_S_RD_REQ 4'h2
`define RTU_S_RD_WAIT 4'h3
`define RTU_S_WR_WAIT 4'h4
`define RTU_S_TX_PREP 4'h5
`define RTU_S_TX_LOAD 4'h6
`define RTU_S_TX_WAIT 4'h7
`define RTU_S_TX_END 4'h8

`endif

// [rtl/rtu_slave_frame_handler.v]
// slave frame handler for the serial register protocol
`timescale 1ns/1ns
`include "rtu_consts.vh"
module rtu_slave_frame_handler #(
  parameter GAP_CYCLES = `RTU_GAP_CYCLES,
  parameter CW = 20,
  parameter MAX_WORDS = `RTU_MAX_WORDS
) (
  input wire clk,
  input wire nrst,
  input wire [7:0] own_addr,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_err,
  input wire tx_ready,
  input wire tx_idle,
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg tx_en,
  output reg [15:0] par_addr,
  output reg [15:0] par_wdata,
  output reg par_rd,
  output reg par_wr,
  output reg par_ram,
  input wire [15:0] par_rdata,
  input wire par_ack,
  input wire par_fail,
  output reg frame_done,
  output reg crc_fault
);

  // ----------------------------------------------------------------
  // check value update, one byte of data bits only
  // ----------------------------------------------------------------
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] r;
    begin
      r = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0]) begin
          r = (r >> 1) ^ `RTU_CRC_POLY;
        end else begin
          r = r >> 1;
        end
      end
      crc_step = r;
    end
  endfunction

  // group test, used for several decisions
  function in_range;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam [CW-1:0] GAP_W = GAP_CYCLES[CW-1:0]; // idle count for a boundary
  reg [3:0] state; // main sequencer
  reg [CW-1:0] idle_cnt; // cycles since last received byte
  reg in_frame; // a frame is being collected
  reg [3:0] rx_cnt; // bytes seen, stops at over-length mark
  reg rx_bad; // uart flagged a character error
  reg [15:0] crc; // shared: receive check, then reply check
  reg [7:0] rx_buf [0:7]; // request bytes
  reg is_bcast; // current request was broadcast
  reg is_exc; // reply is an error reply
  reg [7:0] exc_code; // code for the error reply
  reg [4:0] n_words; // words requested by a read
  reg [3:0] rd_cnt; // words fetched so far
  reg [4:0] tx_idx; // byte of the reply being sent
  reg [4:0] tx_len; // reply length in bytes
  reg [7:0] tx_byte; // next reply byte, combinational
  reg [7:0] dec_exc; // decode verdict, zero when legal
  integer k;

  wire gap_seen = (idle_cnt >= GAP_W);
  wire own_ok = (own_addr != `RTU_BCAST) && (own_addr <= `RTU_ADDR_MAX);
  wire [7:0] cmd = rx_buf[1];
  wire [7:0] grp = rx_buf[2];
  wire [7:0] idx = rx_buf[3];
  wire [15:0] field = {rx_buf[4], rx_buf[5]};
  wire grp_cfg = in_range(grp, `RTU_CFG_LO, `RTU_CFG_HI);
  wire grp_mon = in_range(grp, `RTU_MON_LO, `RTU_MON_HI);
  wire grp_ram = in_range(grp, `RTU_RAM_LO, `RTU_RAM_HI);
  wire [8:0] end_sum = {1'b0, idx} + {5'h00, field[3:0]};
  wire is_read = (cmd == `RTU_CMD_READ);
  wire [4:0] dofs = tx_idx - 5'h03; // data byte offset in read reply
  wire [15:0] mem_q;
  wire mem_we = (state == `RTU_S_RD_WAIT) && par_ack && !par_fail;
  wire [4:0] len_m1 = tx_len - 5'h01;
  wire [4:0] len_m2 = tx_len - 5'h02;
  wire [4:0] rd_len = `RTU_RD_OVH + {n_words[3:0], 1'b0};
  wire [3:0] rd_next = rd_cnt + 4'h1;

  // ----------------------------------------------------------------
  // read data buffer
  // ----------------------------------------------------------------
  word_buffer #(
    .DW(16),
    .AW(4),
    .DEPTH(MAX_WORDS)
  ) u_buf (
    .clk(clk),
    .nrst(nrst),
    .wr_en(mem_we),
    .wr_addr(rd_cnt),
    .wr_data(par_rdata),
    .rd_addr(dofs[4:1]),
    .rd_data(mem_q)
  );

  // ----------------------------------------------------------------
  // request decode: command, count and group checks
  // ----------------------------------------------------------------
  always @* begin
    dec_exc = 8'h00;
    if (is_read) begin
      if (field == 16'h0000 || field > MAX_WORDS) begin
        dec_exc = `RTU_EXC_VALUE;
      end else if (!(grp_cfg || grp_mon || grp_ram) || end_sum > `RTU_IDX_END) begin
        dec_exc = `RTU_EXC_ADDR;
      end
    end else if (cmd == `RTU_CMD_WRITE) begin
      if (!(grp_cfg || grp_ram)) begin
        dec_exc = `RTU_EXC_ADDR;
      end
    end else begin
      dec_exc = `RTU_EXC_CMD;
    end
  end

  // ----------------------------------------------------------------
  // reply byte selection
  // ----------------------------------------------------------------
  always @* begin
    tx_byte = 8'h00;
    if (tx_idx == len_m2) begin
      tx_byte = crc[7:0];
    end else if (tx_idx == len_m1) begin
      tx_byte = crc[15:8];
    end else if (tx_idx == 5'h00) begin
      tx_byte = rx_buf[0];
    end else if (tx_idx == 5'h01) begin
      tx_byte = is_exc ? (cmd | `RTU_EXC_FLAG) : cmd;
    end else if (tx_idx == 5'h02) begin
      if (is_exc) begin
        tx_byte = exc_code;
      end else if (is_read) begin
        tx_byte = {n_words[3:0], 1'b0} + 8'h00;
      end else begin
        tx_byte = rx_buf[2];
      end
    end else if (is_read) begin
      tx_byte = dofs[0] ? mem_q[7:0] : mem_q[15:8];
    end else begin
      tx_byte = rx_buf[tx_idx[2:0]];
    end
  end

  // ----------------------------------------------------------------
  // line idle counter, runs in every state
  // ----------------------------------------------------------------
  // bytes heard while busy still restart it, so a new frame needs a gap
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt <= {CW{1'b0}};
    end else if (rx_valid) begin
      idle_cnt <= {CW{1'b0}};
    end else if (!gap_seen) begin
      idle_cnt <= idle_cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= `RTU_S_RX;
      in_frame <= 1'b0;
      rx_cnt <= 4'h0;
      rx_bad <= 1'b0;
      crc <= `RTU_CRC_INIT;
      for (k = 0; k < 8; k = k + 1) begin
        rx_buf[k] <= 8'h00;
      end
      is_bcast <= 1'b0;
      is_exc <= 1'b0;
      exc_code <= 8'h00;
      n_words <= 5'h00;
      rd_cnt <= 4'h0;
      tx_idx <= 5'h00;
      tx_len <= 5'h00;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_en <= 1'b0;
      par_addr <= 16'h0000;
      par_wdata <= 16'h0000;
      par_rd <= 1'b0;
      par_wr <= 1'b0;
      par_ram <= 1'b0;
      frame_done <= 1'b0;
      crc_fault <= 1'b0;
    end else begin
      par_rd <= 1'b0;
      par_wr <= 1'b0;
      frame_done <= 1'b0;
      crc_fault <= 1'b0;
      case (state)
        `RTU_S_RX: begin
          if (in_frame && gap_seen) begin
            in_frame <= 1'b0;
            frame_done <= 1'b1;
            crc_fault <= (rx_cnt == `RTU_REQ_LEN) && !rx_bad && (crc != 16'h0000);
            // residue zero over all bytes means the check field matched
            if (rx_cnt == `RTU_REQ_LEN && !rx_bad && crc == 16'h0000 &&
                (rx_buf[0] == `RTU_BCAST || (own_ok && rx_buf[0] == own_addr))) begin
              is_bcast <= (rx_buf[0] == `RTU_BCAST);
              state <= `RTU_S_EXEC;
            end
          end else if (rx_valid && (in_frame || gap_seen)) begin
            if (!in_frame) begin
              in_frame <= 1'b1;
              rx_buf[0] <= rx_data;
              rx_cnt <= 4'h1;
              rx_bad <= rx_err;
              crc <= crc_step(`RTU_CRC_INIT, rx_data);
            end else begin
              if (rx_cnt < `RTU_REQ_LEN) begin
                rx_buf[rx_cnt[2:0]] <= rx_data;
              end
              if (rx_cnt != `RTU_REQ_OVER) begin
                rx_cnt <= rx_cnt + 4'h1;
              end
              rx_bad <= rx_bad | rx_err;
              crc <= crc_step(crc, rx_data);
            end
          end
        end
        `RTU_S_EXEC: begin
          if (dec_exc != 8'h00) begin
            if (is_bcast) begin
              state <= `RTU_S_RX;
            end else begin
              is_exc <= 1'b1;
              exc_code <= dec_exc;
              tx_len <= `RTU_EXC_LEN;
              tx_idx <= 5'h00;
              crc <= `RTU_CRC_INIT;
              tx_en <= 1'b1;
              state <= `RTU_S_TX_PREP;
            end
          end else if (is_read) begin
            is_exc <= 1'b0;
            n_words <= field[4:0];
            rd_cnt <= 4'h0;
            // a broadcast read has nobody to answer, so it is dropped
            state <= is_bcast ? `RTU_S_RX : `RTU_S_RD_REQ;
          end else begin
            is_exc <= 1'b0;
            par_addr <= {grp, idx};
            par_wdata <= field;
            par_ram <= grp_ram;
            par_wr <= 1'b1;
            state <= `RTU_S_WR_WAIT;
          end
        end
        `RTU_S_RD_REQ: begin
          par_addr <= {grp, idx + {4'h0, rd_cnt}};
          par_ram <= grp_ram;
          par_rd <= 1'b1;
          state <= `RTU_S_RD_WAIT;
        end
        `RTU_S_RD_WAIT: begin
          if (par_ack) begin
            if (par_fail) begin
              is_exc <= 1'b1;
              exc_code <= `RTU_EXC_FAIL;
              tx_len <= `RTU_EXC_LEN;
              tx_idx <= 5'h00;
              crc <= `RTU_CRC_INIT;
              tx_en <= 1'b1;
              state <= `RTU_S_TX_PREP;
            end else if ({1'b0, rd_next} == n_words) begin
              tx_len <= rd_len;
              tx_idx <= 5'h00;
              crc <= `RTU_CRC_INIT;
              tx_en <= 1'b1;
              state <= `RTU_S_TX_PREP;
            end else begin
              rd_cnt <= rd_next;
              state <= `RTU_S_RD_REQ;
            end
          end
        end
        `RTU_S_WR_WAIT: begin
          if (par_ack) begin
            if (is_bcast) begin
              state <= `RTU_S_RX;
            end else begin
              is_exc <= par_fail;
              exc_code <= `RTU_EXC_FAIL;
              tx_len <= par_fail ? `RTU_EXC_LEN : `RTU_WR_LEN;
              tx_idx <= 5'h00;
              crc <= `RTU_CRC_INIT;
              tx_en <= 1'b1;
              state <= `RTU_S_TX_PREP;
            end
          end
        end
        `RTU_S_TX_PREP: begin
          // gives the buffer one cycle to present the addressed word
          state <= `RTU_S_TX_LOAD;
        end
        `RTU_S_TX_LOAD: begin
          tx_data <= tx_byte;
          tx_valid <= 1'b1;
          if (tx_idx < len_m2) begin
            crc <= crc_step(crc, tx_byte);
          end
          state <= `RTU_S_TX_WAIT;
        end
        `RTU_S_TX_WAIT: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            if (tx_idx == len_m1) begin
              state <= `RTU_S_TX_END;
            end else begin
              tx_idx <= tx_idx + 5'h01;
              state <= `RTU_S_TX_PREP;
            end
          end
        end
        `RTU_S_TX_END: begin
          // hold the driver until the last stop bit has left the shifter
          if (tx_idle) begin
            tx_en <= 1'b0;
            state <= `RTU_S_RX;
          end
        end
        default: begin
          state <= `RTU_S_RX;
        end
      endcase
    end
  end

endmodule

// [rtl/word_buffer.v]
// small word memory holding read data for the reply
`timescale 1ns/1ns
module word_buffer #(
  parameter DW = 16,
  parameter AW = 4,
  parameter DEPTH = 12
) (
  input wire clk,
  input wire nrst,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [DW-1:0] mem [0:DEPTH-1]; // no reset: always written before read

  // write port
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, one cycle after the address
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= {DW{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// [test/param_store_model.sv]
// parameter store model answering the handler's read and write requests
`timescale 1ns/1ns
module param_store_model (
  input wire clk,
  input wire nrst,
  input wire [15:0] par_addr,
  input wire par_rd,
  input wire par_wr,
  output reg [15:0] par_rdata,
  output reg par_ack,
  output reg par_fail
);
  reg [2:0] wait_cnt; // cycles left before the answer
  reg [15:0] held; // word owed to a pending read
  // answer after 1..4 cycles; index ee always fails
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= 3'h0;
      held <= 16'h0;
      par_ack <= 1'b0;
      par_fail <= 1'b0;
      par_rdata <= 16'h0;
    end else if (par_rd || par_wr) begin
      wait_cnt <= {1'b0, par_addr[1:0]} + 3'h1;
      held <= par_addr ^ 16'h5a5a;
      par_ack <= 1'b0;
      par_rdata <= ~par_rdata;
    end else if (wait_cnt == 3'h1) begin
      wait_cnt <= 3'h0;
      par_ack <= 1'b1;
      par_rdata <= held;
      par_fail <= (par_addr[7:0] == 8'hee);
    end else begin
      // data toggles when not valid so a stale word never looks right
      if (wait_cnt != 3'h0) wait_cnt <= wait_cnt - 3'h1;
      par_ack <= 1'b0;
      par_fail <= 1'b0;
      par_rdata <= ~par_rdata;
    end
  end
endmodule

// [test/rtu_handler_checker.sv]
// port assertions for the slave frame handler
`timescale 1ns/1ns
module rtu_handler_checker #(
  parameter GAP_CYCLES = 50,
  parameter CW = 20,
  parameter MAX_WORDS = 12
) (
  input wire clk,
  input wire nrst,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire tx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_en,
  input wire [15:0] par_addr,
  input wire par_rd,
  input wire par_wr,
  input wire par_ram,
  input wire frame_done,
  input wire crc_fault
);
  // ----------------------------------------
  // helper: cycles since the last character
  // ----------------------------------------
  reg [CW-1:0] quiet;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quiet <= {CW{1'b0}};
    end else if (rx_valid) begin
      quiet <= {CW{1'b0}};
    end else if (quiet != {CW{1'b1}}) begin
      quiet <= quiet + 1'b1;
    end
  end
  wire ram_grp = (par_addr[15:8] >= 8'h40) && (par_addr[15:8] <= 8'h5f);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_drive_only_reply: assert property (@(posedge clk) disable iff (!nrst)
    tx_valid |-> tx_en) else $error("reply byte offered with driver off");
  a_enable_leads_tx: assert property (@(posedge clk) disable iff (!nrst)
    $rose(tx_en) |-> !tx_valid ##[1:3] tx_valid) else $error("driver on without a byte");
  a_quiet_on_close: assert property (@(posedge clk) disable iff (!nrst)
    frame_done |-> !tx_en) else $error("driver on while a frame closes");
  a_tx_byte_hold: assert property (@(posedge clk) disable iff (!nrst)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("byte dropped");
  a_gap_close: assert property (@(posedge clk) disable iff (!nrst)
    frame_done |-> quiet > GAP_CYCLES) else $error("frame closed before gap");
  a_done_single: assert property (@(posedge clk) disable iff (!nrst)
    frame_done |=> !frame_done) else $error("frame end held too long");
  a_crc_with_done: assert property (@(posedge clk) disable iff (!nrst)
    crc_fault |-> frame_done) else $error("check fault outside frame end");
  a_one_request: assert property (@(posedge clk) disable iff (!nrst)
    (par_rd || par_wr) |-> !(par_rd && par_wr) ##1 !(par_rd || par_wr))
    else $error("store request not a lone pulse");
  a_mon_write: assert property (@(posedge clk) disable iff (!nrst)
    par_wr |-> par_addr[15:12] != 4'h7) else $error("write reached monitor group");
  a_ram_flag: assert property (@(posedge clk) disable iff (!nrst)
    (par_rd || par_wr) |-> par_ram == ram_grp) else $error("ram flag wrong");
endmodule
bind rtu_slave_frame_handler rtu_handler_checker #(.GAP_CYCLES(GAP_CYCLES), .CW(CW),
  .MAX_WORDS(MAX_WORDS)) chk (.clk(clk), .nrst(nrst), .rx_data(rx_data),
  .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_en(tx_en), .par_addr(par_addr), .par_rd(par_rd), .par_wr(par_wr),
  .par_ram(par_ram), .frame_done(frame_done), .crc_fault(crc_fault));

// [test/tb_top.sv]
// self-checking bench for the slave frame handler
`timescale 1ns/1ns
module tb_top;
  localparam GAP = 50; // short gap keeps the run brief
  localparam [7:0] ME = 8'h11; // own station address
  typedef logic [7:0] bq_t[$];
  logic clk, nrst, rx_valid, rx_err, tx_ready, tx_idle, tx_valid, tx_en;
  logic par_rd, par_wr, par_ram, par_ack, par_fail, frame_done, crc_fault;
  logic saw_crc, saw_done, took;
  logic [7:0] rx_data, tx_data, own_addr;
  logic [15:0] par_addr, par_wdata, par_rdata, last_wa, last_wd;
  int n_errors, num_checks, cyc, n_wr, tx_busy;
  bq_t rq; // reply bytes taken from the handler

  rtu_slave_frame_handler #(.GAP_CYCLES(GAP), .CW(20), .MAX_WORDS(12)) DUT (
    .clk(clk), .nrst(nrst), .own_addr(own_addr), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_err(rx_err), .tx_ready(tx_ready), .tx_idle(tx_idle),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_en(tx_en), .par_addr(par_addr),
    .par_wdata(par_wdata), .par_rd(par_rd), .par_wr(par_wr), .par_ram(par_ram),
    .par_rdata(par_rdata), .par_ack(par_ack), .par_fail(par_fail),
    .frame_done(frame_done), .crc_fault(crc_fault));
  param_store_model store (.clk(clk), .nrst(nrst), .par_addr(par_addr),
    .par_rd(par_rd), .par_wr(par_wr), .par_rdata(par_rdata), .par_ack(par_ack),
    .par_fail(par_fail));

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // monitors, line model and hang limit
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    took <= tx_valid && tx_ready;
    if (tx_valid && tx_ready) rq.push_back(tx_data);
    if (crc_fault) saw_crc = 1;
    if (frame_done) saw_done = 1;
    if (par_wr) begin
      n_wr = n_wr + 1;
      last_wa = par_addr;
      last_wd = par_wdata;
    end
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  // uart stalls at random and stays busy a few cycles per byte
  always @(negedge clk) if (nrst) begin
    tx_ready <= ($urandom % 4) != 0;
    if (took) begin
      tx_idle <= 0;
      tx_busy <= 3;
    end else if (tx_busy > 0) tx_busy <= tx_busy - 1;
    else tx_idle <= 1;
  end
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [15:0] crc16(bq_t b);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // check appended low byte first
  function automatic bq_t seal(bq_t b);
    logic [15:0] c;
    c = crc16(b);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    return b;
  endfunction
  function automatic bq_t req(logic [7:0] a, c, g, i, logic [15:0] w);
    return seal({a, c, g, i, w[15:8], w[7:0]});
  endfunction
  function automatic bq_t expect_reply(bq_t q);
    bq_t r;
    logic [7:0] g, code, ix;
    logic [15:0] n, w;
    g = q[2];
    n = {q[4], q[5]};
    code = 0;
    if (q[0] != ME) return r;
    if (q[1] == 8'h03) begin
      r = {ME, 8'h03, 8'(2 * n)};
      if (n == 0 || n > 12) code = 3;
      else if (!(g inside {[8'h40:8'h5f], [8'h70:8'h7f], [8'ha0:8'hbf]})) code = 2;
      else if (q[3] + n > 16'h100) code = 2;
      else for (int i = 0; i < n; i++) begin
        ix = q[3] + i[7:0];
        w = {g, ix} ^ 16'h5a5a;
        r.push_back(w[15:8]);
        r.push_back(w[7:0]);
        if (ix == 8'hee) code = 4;
      end
    end else if (q[1] == 8'h06) begin
      if (!(g inside {[8'h40:8'h5f], [8'ha0:8'hbf]})) code = 2;
      else if (q[3] == 8'hee) code = 4;
      else r = q[0:5];
    end else code = 1;
    if (code != 0) r = {ME, q[1] | 8'h80, code};
    return seal(r);
  endfunction
  // ----------------------------------------
  // compare, drive, run one request
  // ----------------------------------------
  task automatic check(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(bq_t q, int bad, bit crc_bad, string name);
    bq_t e;
    repeat (GAP + 3) @(negedge clk);
    rq.delete();
    saw_crc = 0;
    saw_done = 0;
    foreach (q[i]) begin
      rx_valid <= 1;
      rx_data <= q[i];
      rx_err <= (i == bad);
      @(negedge clk);
      rx_valid <= 0;
      rx_err <= 0;
      rx_data <= ~q[i];
      repeat ($urandom % 4 + 2) @(negedge clk);
    end
    for (int k = 0; k < GAP + 20 && !saw_done; k++) @(negedge clk);
    for (int k = 0; k < 200 && tx_en !== 1; k++) @(negedge clk);
    for (int k = 0; k < 3000 && tx_en === 1; k++) @(negedge clk);
    if (bad < 0 && !crc_bad && q.size() == 8) e = expect_reply(q);
    check(saw_done, 1);
    check(saw_crc, crc_bad);
    check(tx_en, 0);
    check(rq.size(), e.size());
    // an echoed write must have reached the store with the request's fields
    if (e.size() == 8 && q[1] == 8'h06) begin
      check(last_wa, {q[2], q[3]});
      check(last_wd, {q[4], q[5]});
    end
    foreach (e[i]) if (i < rq.size()) check(rq[i], e[i]);
    $display("test %s done", name);
  endtask
  task complete_run;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    bq_t q;
    logic [7:0] tbl[5] = '{8'ha0, 8'hb0, 8'h40, 8'h50, 8'h70};
    logic [7:0] g, c;
    int nw;
    nrst = 0;
    rx_valid = 0;
    rx_err = 0;
    rx_data = 0;
    tx_ready = 0;
    tx_idle = 1;
    own_addr = ME;
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    n_wr = 0;
    tx_busy = 0;
    saw_crc = 0;
    saw_done = 0;
    took = 0;
    void'($urandom(30137));
    repeat (4) @(negedge clk);
    nrst = 1;
    run(req(ME, 8'h03, 8'ha0, 8'h05, 1), -1, 0, "read one");
    run(req(ME, 8'h03, 8'hbf, 8'hf4, 12), -1, 0, "read to end");
    run(req(ME, 8'h03, 8'ha1, 8'hf5, 12), -1, 0, "read across");
    run(req(ME, 8'h03, 8'ha0, 8'h00, 0), -1, 0, "count zero");
    run(req(ME, 8'h03, 8'ha0, 8'h00, 13), -1, 0, "count over");
    run(req(ME, 8'h03, 8'h70, 8'h10, 3), -1, 0, "monitor read");
    run(req(ME, 8'h03, 8'h10, 8'h00, 1), -1, 0, "bad group");
    run(req(ME, 8'h06, 8'hb2, 8'h33, 16'hbeef), -1, 0, "write cfg");
    run(req(ME, 8'h06, 8'h40, 8'h07, 16'h1234), -1, 0, "write ram");
    run(req(ME, 8'h06, 8'h70, 8'h01, 16'h0001), -1, 0, "write monitor");
    run(req(ME, 8'h03, 8'ha0, 8'hec, 4), -1, 0, "read fail");
    run(req(ME, 8'h06, 8'ha0, 8'hee, 16'h0bad), -1, 0, "write fail");
    foreach (tbl[i]) begin
      c = (i == 4) ? 8'h10 : 8'(i + 1 + (i > 1));
      run(req(ME, c, 8'ha0, 8'h00, 1), -1, 0, "bad command");
    end
    nw = n_wr;
    run(req(8'h00, 8'h06, 8'ha2, 8'h10, 16'h5555), -1, 0, "broadcast write");
    check(n_wr - nw, 1);
    check(last_wd, 16'h5555);
    run(req(8'h00, 8'h03, 8'ha2, 8'h10, 1), -1, 0, "broadcast read");
    run(req(8'h12, 8'h03, 8'ha0, 8'h00, 1), -1, 0, "other station");
    own_addr = 8'hf8; // out of range: only broadcast may pass
    run(req(8'hf8, 8'h03, 8'ha0, 8'h00, 1), -1, 0, "invalid own");
    own_addr = ME;
    q = req(ME, 8'h03, 8'ha0, 8'h01, 2);
    q[7] = q[7] ^ 8'h01;
    run(q, -1, 1, "bad check");
    run(req(ME, 8'h03, 8'ha0, 8'h01, 2), 3, 0, "line error");
    q = req(ME, 8'h03, 8'ha0, 8'h01, 2);
    void'(q.pop_back());
    run(q, -1, 0, "truncated");
    repeat (25) begin
      c = ($urandom % 2) ? 8'h03 : 8'h06;
      g = tbl[$urandom % 5] + 8'($urandom % 16);
      run(req(ME, c, g, 8'($urandom), (c == 8'h03) ? 16'($urandom % 12 + 1) :
        16'($urandom)), -1, 0, "random");
    end
    complete_run();
  end
endmodule
